/* File: rtl/uart_abw_pkg.sv */
// Constants shared by the device end and the remote serial node end.
// Assumes one 50 MHz system clock and an asynchronous active-low reset.
// How it works
// - Enable bit starts line-timed divisor measurement
// - Receive state machine idles while measuring
// - Count 55h from first rise to fifth
// - Fifth rise stores count, clears enable, flags
// - Data read clears receive flag; value discarded
// - Both divisor bytes form one counter
// - Count at base clock over eight
// - Count starts at one; software subtracts one
// - Overflow flagged, counting continues to fifth
// - Overflow clears only by write, enable low
// - Wake plus measurement measures byte after break
// - Wake enable stops reception, receiver idles
// - Falling line edge is wake, sets flag
// - Next rising edge clears wake enable
// - Remote sends ten-plus zero bits, then idle
// - Non-zero character: first low is wake
// - Software checks receiver idle before wake enable
// - Break is start, twelve zeros, stop
// - Send-break write sends zeros, ignores data
// - Send-break clears after stop; preload follows
// - Shift-empty status tracks breaks like characters
// - Transmit flag set when data register empties
package uart_abw_pkg;

    // ------------------------------------------------------------
    // Clock dividers, index {divisor_wide_select, high_speed_select}
    // ------------------------------------------------------------
    localparam logic [9:0] BASE_DIV_00    = 10'h040;
    localparam logic [9:0] BASE_DIV_01    = 10'h010;
    localparam logic [9:0] BASE_DIV_10    = 10'h010;
    localparam logic [9:0] BASE_DIV_11    = 10'h004;
    localparam int         MEASURE_SHIFT  = 3;

    // ------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------
    localparam logic [3:0] FRAME_BITS     = 4'ha;
    localparam logic [3:0] BREAK_BITS     = 4'he;
    localparam logic [2:0] SYNC_RISES     = 3'h5;
    localparam logic [7:0] SYNC_CHAR      = 8'h55;
    localparam logic [15:0] COUNT_START   = 16'h0001;
    localparam logic [15:0] DIVISOR_RESET = 16'h0000;
    localparam logic [4:0] MIN_WAKE_BITS  = 5'h0a;
    localparam logic [4:0] WAKE_IDLE_BITS = 5'h02;

    // ------------------------------------------------------------
    // State encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RX_IDLE      = 2'b00,
        RX_ARM       = 2'b01,
        RX_WAIT_RISE = 2'b10,
        RX_COUNT     = 2'b11
    } rx_state_t;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_SHIFT = 2'b01,
        TX_ZERO  = 2'b10,
        TX_GAP   = 2'b11
    } tx_state_t;

endpackage : uart_abw_pkg

/* File: rtl/uart_link_if.sv */
// Serial link between the device and the remote node.
// Assumes idle-high lines, each driven by exactly one end.
`timescale 1ns/1ps
interface uart_link_if;
    logic receive_line;
    logic transmit_line;

    modport device (input receive_line, output transmit_line);
    modport remote (output receive_line, input transmit_line);
endinterface : uart_link_if

/* File: rtl/uart_abw_device.sv */
// Device end: auto-baud measurement, wake-on-break and break transmission.
// Assumes software drives the control pulses synchronously to clk.
`timescale 1ns/1ps
module uart_abw_device
    import uart_abw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    uart_link_if.device      link,
    input  wire logic        autobaud_enable_set,
    input  wire logic        autobaud_enable_clr,
    input  wire logic        overflow_clr,
    input  wire logic        wake_enable_set,
    input  wire logic        wake_enable_clr,
    input  wire logic        divisor_wide_select,
    input  wire logic        high_speed_select,
    input  wire logic        divisor_write,
    input  wire logic [15:0] divisor_wdata,
    input  wire logic        receive_data_read,
    input  wire logic        transmit_enable,
    input  wire logic        send_break_set,
    input  wire logic        transmit_write,
    input  wire logic [7:0]  transmit_wdata,
    output logic             autobaud_enable,
    output logic             baud_measure_overflow,
    output logic             wake_on_break_enable,
    output logic             receive_flag,
    output logic             receiver_idle,
    output logic [15:0]      baud_divider,
    output logic [7:0]       receive_data_reg,
    output logic             send_break,
    output logic             shift_empty_status,
    output logic             transmit_flag
);

    // ------------------------------------------------------------
    // Receive line synchroniser and edges
    // ------------------------------------------------------------
    logic       rx_meta_reg;
    logic       rx_sync_reg;
    logic       rx_prev_reg;
    logic       rx_fell;
    logic       rx_rose;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
            rx_prev_reg <= 1'b1;
        end else begin
            rx_meta_reg <= link.receive_line;
            rx_sync_reg <= rx_meta_reg;
            rx_prev_reg <= rx_sync_reg;
        end
    end

    assign rx_fell = rx_prev_reg & ~rx_sync_reg;
    assign rx_rose = ~rx_prev_reg & rx_sync_reg;

    // ------------------------------------------------------------
    // Divider selection
    // ------------------------------------------------------------
    logic [9:0]  base_div;
    logic [12:0] measure_div;

    always_comb begin
        case ({divisor_wide_select, high_speed_select})
            2'b00:   base_div = BASE_DIV_00;
            2'b01:   base_div = BASE_DIV_01;
            2'b10:   base_div = BASE_DIV_10;
            default: base_div = BASE_DIV_11;
        endcase
    end

    assign measure_div = {base_div, 3'b000};

    // ------------------------------------------------------------
    // Wake-on-break
    // ------------------------------------------------------------
    logic wake_low_reg;
    logic wake_event;
    logic wake_end;

    assign wake_event = wake_on_break_enable & ~wake_low_reg & rx_fell;
    assign wake_end   = wake_on_break_enable & wake_low_reg & rx_rose;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_on_break_enable <= 1'b0;
            wake_low_reg         <= 1'b0;
        end else begin
            if (wake_end || wake_enable_clr) begin
                wake_on_break_enable <= 1'b0;
                wake_low_reg         <= 1'b0;
            end else if (wake_enable_set) begin
                wake_on_break_enable <= 1'b1;
            end
            if (wake_event && !wake_enable_clr) begin
                wake_low_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Auto-baud measurement
    // ------------------------------------------------------------
    rx_state_t   rx_state_reg;
    rx_state_t   rx_state_next;
    logic [12:0] pre_cnt_reg;
    logic [15:0] meas_cnt_reg;
    logic [2:0]  rises_reg;
    logic        meas_tick;
    logic        meas_done;

    assign meas_tick = (rx_state_reg == RX_COUNT) && (pre_cnt_reg == measure_div - 13'h0001);
    assign meas_done = (rx_state_reg == RX_COUNT) && rx_rose && (rises_reg == SYNC_RISES - 3'h2);

    always_comb begin
        rx_state_next = rx_state_reg;
        case (rx_state_reg)
            RX_IDLE: begin
                if (autobaud_enable && !wake_on_break_enable) begin
                    rx_state_next = RX_ARM;
                end
            end
            RX_ARM: begin
                if (rx_fell) begin
                    rx_state_next = RX_WAIT_RISE;
                end
            end
            RX_WAIT_RISE: begin
                if (rx_rose) begin
                    rx_state_next = RX_COUNT;
                end
            end
            RX_COUNT: begin
                if (meas_done) begin
                    rx_state_next = RX_IDLE;
                end
            end
            default: rx_state_next = RX_IDLE;
        endcase
        if (!autobaud_enable || wake_on_break_enable) begin
            rx_state_next = RX_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_reg  <= RX_IDLE;
            receiver_idle <= 1'b1;
        end else begin
            rx_state_reg  <= rx_state_next;
            receiver_idle <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_reg  <= 13'h0000;
            meas_cnt_reg <= COUNT_START;
            rises_reg    <= 3'h0;
        end else if (rx_state_reg != RX_COUNT) begin
            pre_cnt_reg  <= 13'h0000;
            meas_cnt_reg <= COUNT_START;
            rises_reg    <= 3'h0;
        end else begin
            pre_cnt_reg <= meas_tick ? 13'h0000 : pre_cnt_reg + 13'h0001;
            if (meas_tick) begin
                meas_cnt_reg <= meas_cnt_reg + 16'h0001;
            end
            if (rx_rose) begin
                rises_reg <= rises_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            autobaud_enable <= 1'b0;
        end else if (meas_done || autobaud_enable_clr) begin
            autobaud_enable <= 1'b0;
        end else if (autobaud_enable_set) begin
            autobaud_enable <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            baud_measure_overflow <= 1'b0;
        end else if (meas_tick && meas_cnt_reg == 16'hffff) begin
            baud_measure_overflow <= 1'b1;
        end else if (overflow_clr && !autobaud_enable) begin
            baud_measure_overflow <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            baud_divider <= DIVISOR_RESET;
        end else if (meas_done) begin
            baud_divider <= meas_cnt_reg + {15'h0000, meas_tick};
        end else if (divisor_write) begin
            baud_divider <= divisor_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            receive_flag     <= 1'b0;
            receive_data_reg <= 8'h00;
        end else begin
            receive_data_reg <= 8'h00;
            if (meas_done || wake_event) begin
                receive_flag <= 1'b1;
            end else if (receive_data_read) begin
                receive_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    tx_state_t   tx_state_reg;
    logic [13:0] tx_shift_reg;
    logic [3:0]  tx_left_reg;
    logic [9:0]  tx_pre_reg;
    logic [15:0] tx_div_reg;
    logic        tx_bit_end;
    logic [7:0]  hold_data_reg;
    logic        hold_break_reg;
    logic        shift_break_reg;
    logic        break_taken_reg;
    logic        take_write;
    logic        load_shift;

    assign tx_bit_end = (tx_pre_reg == base_div - 10'h001) && (tx_div_reg == baud_divider);
    assign take_write = transmit_write && transmit_enable && transmit_flag;
    assign load_shift = (tx_state_reg == TX_IDLE) && !transmit_flag;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            transmit_flag   <= 1'b1;
            hold_data_reg   <= 8'h00;
            hold_break_reg  <= 1'b0;
            break_taken_reg <= 1'b0;
        end else begin
            if (take_write) begin
                transmit_flag   <= 1'b0;
                hold_data_reg   <= transmit_wdata;
                hold_break_reg  <= send_break && !break_taken_reg;
                break_taken_reg <= send_break;
            end else if (load_shift) begin
                transmit_flag <= 1'b1;
            end
            if (!send_break) begin
                break_taken_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_reg       <= TX_IDLE;
            tx_shift_reg       <= 14'h3fff;
            tx_left_reg        <= 4'h0;
            tx_pre_reg         <= 10'h000;
            tx_div_reg         <= 16'h0000;
            shift_break_reg    <= 1'b0;
            shift_empty_status <= 1'b1;
            link.transmit_line <= 1'b1;
        end else if (load_shift) begin
            tx_state_reg       <= TX_SHIFT;
            shift_empty_status <= 1'b0;
            shift_break_reg    <= hold_break_reg;
            tx_pre_reg         <= 10'h000;
            tx_div_reg         <= 16'h0000;
            link.transmit_line <= 1'b0;
            if (hold_break_reg) begin
                tx_shift_reg <= {1'b1, 13'h0000};
                tx_left_reg  <= BREAK_BITS;
            end else begin
                tx_shift_reg <= {5'h1f, hold_data_reg, 1'b0};
                tx_left_reg  <= FRAME_BITS;
            end
        end else if (tx_state_reg == TX_SHIFT) begin
            if (tx_pre_reg == base_div - 10'h001) begin
                tx_pre_reg <= 10'h000;
                tx_div_reg <= tx_bit_end ? 16'h0000 : tx_div_reg + 16'h0001;
            end else begin
                tx_pre_reg <= tx_pre_reg + 10'h001;
            end
            if (tx_bit_end) begin
                if (tx_left_reg == 4'h1) begin
                    tx_state_reg       <= TX_IDLE;
                    shift_empty_status <= 1'b1;
                    link.transmit_line <= 1'b1;
                end else begin
                    tx_shift_reg       <= {1'b1, tx_shift_reg[13:1]};
                    link.transmit_line <= tx_shift_reg[1];
                end
                tx_left_reg <= tx_left_reg - 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            send_break <= 1'b0;
        end else if (tx_state_reg == TX_SHIFT && tx_bit_end && tx_left_reg == 4'h1 && shift_break_reg) begin
            send_break <= 1'b0;
        end else if (send_break_set) begin
            send_break <= 1'b1;
        end
    end

endmodule : uart_abw_device

/* File: rtl/uart_abw_remote.sv */
// Remote serial node end: sends characters and wake/break runs of zeros.
// Assumes the caller gives the bit time in system clock cycles.
`timescale 1ns/1ps
module uart_abw_remote
    import uart_abw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    uart_link_if.remote      link,
    input  wire logic        send_start,
    input  wire logic [7:0]  send_data,
    input  wire logic [4:0]  send_zero_bits,
    input  wire logic [15:0] bit_cycles,
    output logic             send_busy,
    output logic             device_line
);

    // ------------------------------------------------------------
    // Device line observation
    // ------------------------------------------------------------
    logic dev_meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dev_meta_reg <= 1'b1;
            device_line  <= 1'b1;
        end else begin
            dev_meta_reg <= link.transmit_line;
            device_line  <= dev_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Sender
    // ------------------------------------------------------------
    tx_state_t   state_reg;
    logic [9:0]  shift_reg;
    logic [4:0]  left_reg;
    logic [15:0] cyc_reg;
    logic        bit_end;

    assign bit_end = (cyc_reg == bit_cycles - 16'h0001);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg         <= TX_IDLE;
            shift_reg         <= 10'h3ff;
            left_reg          <= 5'h00;
            cyc_reg           <= 16'h0000;
            send_busy         <= 1'b0;
            link.receive_line <= 1'b1;
        end else begin
            cyc_reg <= (state_reg == TX_IDLE || bit_end) ? 16'h0000 : cyc_reg + 16'h0001;
            case (state_reg)
                TX_IDLE: begin
                    if (send_start) begin
                        send_busy         <= 1'b1;
                        link.receive_line <= 1'b0;
                        if (send_zero_bits != 5'h00) begin
                            state_reg <= TX_ZERO;
                            left_reg  <= (send_zero_bits < MIN_WAKE_BITS) ? MIN_WAKE_BITS : send_zero_bits;
                        end else begin
                            state_reg <= TX_SHIFT;
                            shift_reg <= {1'b1, send_data, 1'b0};
                            left_reg  <= {1'b0, FRAME_BITS};
                        end
                    end
                end
                TX_SHIFT: begin
                    if (bit_end) begin
                        if (left_reg == 5'h01) begin
                            state_reg         <= TX_IDLE;
                            send_busy         <= 1'b0;
                            link.receive_line <= 1'b1;
                        end else begin
                            shift_reg         <= {1'b1, shift_reg[9:1]};
                            link.receive_line <= shift_reg[1];
                        end
                        left_reg <= left_reg - 5'h01;
                    end
                end
                TX_ZERO: begin
                    if (bit_end) begin
                        if (left_reg == 5'h01) begin
                            state_reg         <= TX_GAP;
                            left_reg          <= WAKE_IDLE_BITS;
                            link.receive_line <= 1'b1;
                        end else begin
                            left_reg <= left_reg - 5'h01;
                        end
                    end
                end
                TX_GAP: begin
                    if (bit_end) begin
                        if (left_reg == 5'h01) begin
                            state_reg <= TX_IDLE;
                            send_busy <= 1'b0;
                        end
                        left_reg <= left_reg - 5'h01;
                    end
                end
                default: state_reg <= TX_IDLE;
            endcase
        end
    end

endmodule : uart_abw_remote

/* File: tb/uart_abw_checker.sv */
// Checker for the serial link and the device end's flags.
// Assumes it is placed beside the link interface in the bench top.
`timescale 1ns/1ps
module uart_abw_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        receive_line,
    input wire logic        transmit_line,
    input wire logic        autobaud_enable_clr,
    input wire logic        overflow_clr,
    input wire logic        divisor_write,
    input wire logic        receive_data_read,
    input wire logic        transmit_write,
    input wire logic        transmit_enable,
    input wire logic        autobaud_enable,
    input wire logic        baud_measure_overflow,
    input wire logic        wake_on_break_enable,
    input wire logic        receive_flag,
    input wire logic        receiver_idle,
    input wire logic [15:0] baud_divider,
    input wire logic        send_break,
    input wire logic        shift_empty_status,
    input wire logic        transmit_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Measurement and wake
    // ------------------------------------------------------------
    a_rx_held_idle: assert property (autobaud_enable |-> receiver_idle)
        else $error("receiver active while measuring");
    a_fifth_rise_done: assert property ($fell(autobaud_enable) && !$past(autobaud_enable_clr) |-> receive_flag)
        else $error("measurement ended without receive flag");
    a_divisor_held: assert property (!autobaud_enable && !divisor_write ##1 !autobaud_enable |-> $stable(baud_divider))
        else $error("divisor changed outside measurement");
    a_overflow_kept: assert property (baud_measure_overflow && autobaud_enable |=> baud_measure_overflow)
        else $error("overflow dropped while enabled");
    a_overflow_by_write: assert property ($fell(baud_measure_overflow) |-> $past(overflow_clr))
        else $error("overflow cleared without write");
    a_flag_by_read: assert property ($fell(receive_flag) |-> $past(receive_data_read))
        else $error("receive flag cleared without read");
    a_wake_flag_set: assert property (wake_on_break_enable && $fell(receive_line) |-> ##[1:5] receive_flag)
        else $error("wake edge did not raise flag");
    a_wake_ends_rise: assert property (wake_on_break_enable && $rose(receive_line) |-> ##[1:5] !wake_on_break_enable)
        else $error("wake enable not cleared by rise");

    // ------------------------------------------------------------
    // Transmit
    // ------------------------------------------------------------
    a_stop_after_break: assert property ($fell(send_break) |-> transmit_line)
        else $error("send break cleared before stop bit");
    a_idle_line_high: assert property (shift_empty_status |-> transmit_line)
        else $error("line low while shifter empty");
    a_tx_flag_drop: assert property (transmit_write && transmit_enable && transmit_flag |=> !transmit_flag)
        else $error("transmit flag kept after write");
    a_tx_flag_refill: assert property (!transmit_flag && shift_empty_status |=> transmit_flag)
        else $error("transmit flag not restored");

    c_measure_done: cover property ($fell(autobaud_enable) && receive_flag);
    c_wake_done: cover property ($fell(wake_on_break_enable));
    c_break_done: cover property ($fell(send_break));
endmodule : uart_abw_checker

/* File: tb/uart_autobaud_wake_break_bench.sv */
// Bench joining the device end and the remote node over one link.
// Assumes the package, interface and both design ends compile first.
`timescale 1ns/1ps
module uart_autobaud_wake_break_bench;
    import uart_abw_pkg::*;

    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic        clk = 1'b0, rst_n = 1'b0, autobaud_enable_set = 1'b0, autobaud_enable_clr = 1'b0;
    logic        overflow_clr = 1'b0, wake_enable_set = 1'b0, wake_enable_clr = 1'b0, divisor_write = 1'b0;
    logic        divisor_wide_select = 1'b0, high_speed_select = 1'b0, receive_data_read = 1'b0;
    logic        transmit_enable = 1'b0, send_break_set = 1'b0, transmit_write = 1'b0, send_start = 1'b0;
    logic [15:0] divisor_wdata = 16'h0000, bit_cycles = 16'h0010;
    logic [7:0]  transmit_wdata = 8'h00, send_data = 8'h00;
    logic [4:0]  send_zero_bits = 5'h00;
    logic        autobaud_enable, baud_measure_overflow, wake_on_break_enable, receive_flag, receiver_idle;
    logic        send_break, shift_empty_status, transmit_flag, send_busy;
    logic [15:0] baud_divider;
    logic [7:0]  receive_data_reg;
    logic [23:0] wave;
    int          err_total = 0, comparisons = 0, base;

    uart_link_if uart_link_if_i ();
    uart_abw_device uart_abw_device_i (.clk, .rst_n, .link(uart_link_if_i.device), .autobaud_enable_set,
        .autobaud_enable_clr, .overflow_clr, .wake_enable_set, .wake_enable_clr, .divisor_wide_select,
        .high_speed_select, .divisor_write, .divisor_wdata, .receive_data_read, .transmit_enable,
        .send_break_set, .transmit_write, .transmit_wdata, .autobaud_enable, .baud_measure_overflow,
        .wake_on_break_enable, .receive_flag, .receiver_idle, .baud_divider, .receive_data_reg,
        .send_break, .shift_empty_status, .transmit_flag);
    uart_abw_remote uart_abw_remote_i (.clk, .rst_n, .link(uart_link_if_i.remote), .send_start, .send_data,
        .send_zero_bits, .bit_cycles, .send_busy, .device_line());
    uart_abw_checker uart_abw_checker_i (.clk, .rst_n, .receive_line(uart_link_if_i.receive_line),
        .transmit_line(uart_link_if_i.transmit_line), .autobaud_enable_clr, .overflow_clr, .divisor_write,
        .receive_data_read, .transmit_write, .transmit_enable, .autobaud_enable, .baud_measure_overflow,
        .wake_on_break_enable, .receive_flag, .receiver_idle, .baud_divider, .send_break,
        .shift_empty_status, .transmit_flag);

    always #10 clk = ~clk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #2;
    endtask : step

    task automatic pulse(ref logic s);
        s = 1'b1;
        step();
        s = 1'b0;
    endtask : pulse

    task automatic send(input logic [7:0] d, input logic [4:0] z, input logic [15:0] b);
        int i;
        send_data = d;
        send_zero_bits = z;
        bit_cycles = b;
        pulse(send_start);
        for (i = 0; i < 40 * b && send_busy !== 1'b0; i++) step();
        if (send_busy !== 1'b0) begin
            err_total++;
            finish_test();
        end
        step(4);
    endtask : send

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        #2 rst_n = 1'b1;
        step();
        check("reset_flags", {transmit_flag, shift_empty_status, receiver_idle, receive_flag}, 16'h000e);
        check("reset_divisor", baud_divider, 16'h0000);
        for (int m = 0; m < 4; m++) begin
            {divisor_wide_select, high_speed_select} = m[1:0];
            base = (m == 0) ? 64 : (m == 3) ? 4 : 16;
            pulse(autobaud_enable_set);
            send(SYNC_CHAR, 5'h00, 16'(16 * base));
            check("measure_flags", {autobaud_enable, receive_flag, receiver_idle}, 16'h0003);
            check("measure_count", baud_divider, 16'h0011);
            pulse(receive_data_read);
            check("read_clears", {receive_flag, receive_data_reg}, 16'h0000);
        end
        pulse(autobaud_enable_set);
        pulse(autobaud_enable_clr);
        pulse(overflow_clr);
        send(SYNC_CHAR, 5'h00, 16'h0040);
        check("abort", {autobaud_enable, receive_flag, baud_measure_overflow}, 16'h0000);
        check("idle_before_wake", receiver_idle, 16'h0001);
        pulse(autobaud_enable_set);
        pulse(wake_enable_set);
        send(8'h00, 5'h0d, 16'h0040);
        check("wake_seen", {wake_on_break_enable, receive_flag, autobaud_enable}, 16'h0003);
        pulse(receive_data_read);
        send(SYNC_CHAR, 5'h00, 16'h0040);
        check("after_break", {autobaud_enable, receive_flag}, 16'h0001);
        check("after_break_count", baud_divider, 16'h0011);
        pulse(receive_data_read);
        pulse(wake_enable_set);
        send(8'hf0, 5'h00, 16'h0040);
        check("fragment_wake", {wake_on_break_enable, receive_flag, receiver_idle}, 16'h0003);
        pulse(receive_data_read);
        divisor_wdata = 16'h0001;
        pulse(divisor_write);
        transmit_wdata = 8'haa;
        pulse(transmit_write);
        check("tx_refused", {transmit_flag, shift_empty_status}, 16'h0003);
        transmit_enable = 1'b1;
        pulse(send_break_set);
        check("break_armed", send_break, 16'h0001);
        transmit_wdata = 8'hff;
        pulse(transmit_write);
        step();
        transmit_wdata = SYNC_CHAR;
        pulse(transmit_write);
        step(3);
        wave = {1'b1, SYNC_CHAR, 1'b0, 1'b1, 13'h0000};
        for (int k = 0; k < 24; k++) begin
            check("tx_line", uart_link_if_i.transmit_line, wave[k]);
            if (k == 6) check("break_busy", {send_break, shift_empty_status, transmit_flag}, 16'h0004);
            if (k == 15) check("break_done", send_break, 16'h0000);
            step(8);
        end
        check("tx_done", {transmit_flag, shift_empty_status}, 16'h0003);
        finish_test();
    end
endmodule : uart_autobaud_wake_break_bench
